// >>> logic/oag_defs.svh
// address constants for the operand address generator
// assumes a 16-bit address space and an 8-bit register file of 8 bytes
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH

`define OAG_SADDR_LO 16'hFE20
`define OAG_SADDR_HI 16'hFF1F
`define OAG_SADDR_SPLIT 8'h20
`define OAG_SADDR_TOP 7'h7F
`define OAG_SFR_BASE 16'hFF00
`define OAG_SFR_PAGE 8'hFF
`define OAG_RAM_LO 16'hFE00
`define OAG_RAM_HI 16'hFEFF
`define OAG_BYTE_W 8
`define OAG_PAIR_BASE 2'h3
`define OAG_PAIR_PTR 2'h2
`define OAG_EA_RST 16'h0000

`endif

// >>> logic/oag_pkg.sv
// types shared by the operand address generator and its register select
// assumes oag_defs.svh is compiled alongside
package oag_pkg;

  typedef enum logic [2:0] {
    OAG_SADDR,
    OAG_SFR,
    OAG_REG8,
    OAG_REG16,
    OAG_IND_PTR,
    OAG_IND_BASE,
    OAG_BASED,
    OAG_STACK
  } oag_mode_t;

  // function names of byte registers; absolute numbers are the same codes
  typedef enum logic [2:0] {
    OAG_R_X, OAG_R_A, OAG_R_C, OAG_R_B,
    OAG_R_E, OAG_R_D, OAG_R_L, OAG_R_H
  } oag_byte_reg_t;

  typedef enum logic [1:0] {
    OAG_P_AX, OAG_P_BC, OAG_P_SECOND, OAG_P_BASE
  } oag_pair_reg_t;

endpackage

// >>> logic/oag_regsel.sv
// byte and pair selection out of the eight-byte register file image
// assumes byte n of the image sits at bits 8n+7..8n
`timescale 1ns/1ns
`include "oag_defs.svh"
module oag_regsel (
  oag_rf_if.sel rf
);

  // a pair n is byte 2n+1 high and byte 2n low
  function automatic logic [15:0] pair_of(input logic [63:0] img,
                                           input logic [1:0] code);
    pair_of = img[{code, 4'h0} +: 16];
  endfunction

  assign rf.byte_val = rf.rf_image[{rf.byte_code, 3'h0} +: `OAG_BYTE_W];
  assign rf.pair_val = pair_of(rf.rf_image, rf.pair_code);
  assign rf.base_pair = pair_of(rf.rf_image, `OAG_PAIR_BASE);
  assign rf.second_pointer_pair = pair_of(rf.rf_image, `OAG_PAIR_PTR);

endmodule

// >>> logic/oag_rf_if.sv
// register file view passed between the generator and its register select
// assumes one clock domain; all signals are combinational
`timescale 1ns/1ns
interface oag_rf_if;
  logic [63:0] rf_image;
  logic [2:0] byte_code;
  logic [1:0] pair_code;
  logic [7:0] byte_val;
  logic [15:0] pair_val;
  logic [15:0] base_pair;
  logic [15:0] second_pointer_pair;

  modport sel (
    input rf_image, byte_code, pair_code,
    output byte_val, pair_val, base_pair, second_pointer_pair
  );
  modport user (
    output rf_image, byte_code, pair_code,
    input byte_val, pair_val, base_pair, second_pointer_pair
  );
endinterface

// >>> logic/oag_top.sv
// operand effective-address generator for an 8-bit core
// assumes the decoder presents one request per cycle with stable fields
// and the register file image and stack pointer on the same clock
//
// Operation
// - short direct maps the 8-bit field into the FE20H..FF1FH window.
// - that window reaches high-speed RAM below FF00H, SFRs from FF00H.
// - short direct bit 8 is 0 for fields 20H..FFH and 1 for 00H..1FH.
// - the pair form of short direct reaches even addresses only.
// - SFR addressing selects within the 256 bytes from FF00H.
// - SFRs at FF00H..FF1FH give the same address either way.
// - a byte register operand is one of eight chosen by 3 bits.
// - registers are chosen by number, bytes 0..7 and pairs 0..3.
// - register indirect uses the second pointer pair or base pair.
// - based adds the zero-extended offset to the base pair mod 2^16.
// - stack accesses are addressed through the stack pointer.
// - stack accesses may target the high-speed RAM only.
`timescale 1ns/1ns
`include "oag_defs.svh"
module oag_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_vld,
  input wire oag_pkg::oag_mode_t mode,
  input wire logic [7:0] op_field,
  input wire logic [2:0] byte_code,
  input wire logic [1:0] pair_code,
  input wire logic pair_op,
  input wire logic push_op,
  input wire logic [63:0] rf_image,
  input wire logic [15:0] stack_pointer,
  output logic ea_vld_ff,
  output logic [15:0] ea_ff,
  output logic ram_hit_ff,
  output logic sfr_hit_ff,
  output logic reg_hit_ff,
  output logic [15:0] reg_val_ff,
  output logic fault_ff
);

  oag_rf_if rf ();

  assign rf.rf_image = rf_image;
  assign rf.byte_code = byte_code;
  assign rf.pair_code = pair_code;

  oag_regsel u_regsel (
    .rf(rf.sel)
  );

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= `OAG_RAM_LO) && (a <= `OAG_RAM_HI);
  endfunction

  function automatic logic in_sfr(input logic [15:0] a);
    in_sfr = (a >= `OAG_SFR_BASE);
  endfunction

  // zero-extended offset, carry out of bit 15 dropped
  function automatic logic [15:0] add_off(input logic [15:0] b,
                                          input logic [7:0] off);
    add_off = b + {8'h00, off};
  endfunction

  logic saddr_sfr_side;
  logic [7:0] saddr_low;
  logic [15:0] saddr_ea;
  logic [15:0] sfr_ea;
  logic [15:0] ind_ea;
  logic [15:0] based_ea;
  logic [15:0] stack_ea;
  logic odd_pair;
  logic stack_out;
  logic is_reg;
  logic is_mem;
  logic [15:0] nxt_ea;
  logic [15:0] nxt_reg_val;
  logic nxt_fault;
  logic nxt_vld;

  // fields below 20H fold onto the SFR page
  assign saddr_sfr_side = op_field < `OAG_SADDR_SPLIT;
  // pair operands never straddle; low bit is dropped and flagged
  assign saddr_low = pair_op ? {op_field[7:1], 1'h0} : op_field;
  assign saddr_ea = {`OAG_SADDR_TOP, saddr_sfr_side, saddr_low};
  assign sfr_ea = {`OAG_SFR_PAGE, op_field};
  assign ind_ea = (mode == oag_pkg::OAG_IND_PTR) ?
                  rf.second_pointer_pair : rf.base_pair;
  assign based_ea = add_off(rf.base_pair, op_field);
  // push-type accesses use the predecremented pointer
  assign stack_ea = push_op ? stack_pointer - 16'h0001 :
                    stack_pointer;
  assign odd_pair = (mode == oag_pkg::OAG_SADDR) && pair_op &&
                    op_field[0];
  // a stray stack pointer is blocked rather than corrupting SFRs
  assign stack_out = (mode == oag_pkg::OAG_STACK) &&
                     !in_ram(stack_ea);
  assign is_reg = (mode == oag_pkg::OAG_REG8) ||
                  (mode == oag_pkg::OAG_REG16);
  assign is_mem = !is_reg;
  // a faulted request still loads ea_ff; only its flags are held back
  assign nxt_fault = req_vld && (odd_pair || stack_out);
  assign nxt_vld = req_vld && !nxt_fault;

  always_comb begin
    case (mode)
      oag_pkg::OAG_SADDR: nxt_ea = saddr_ea;
      oag_pkg::OAG_SFR: nxt_ea = sfr_ea;
      oag_pkg::OAG_IND_PTR: nxt_ea = ind_ea;
      oag_pkg::OAG_IND_BASE: nxt_ea = ind_ea;
      oag_pkg::OAG_BASED: nxt_ea = based_ea;
      oag_pkg::OAG_STACK: nxt_ea = stack_ea;
      default: nxt_ea = `OAG_EA_RST;
    endcase
  end

  always_comb begin
    case (mode)
      oag_pkg::OAG_REG8: nxt_reg_val = {8'h00, rf.byte_val};
      oag_pkg::OAG_REG16: nxt_reg_val = rf.pair_val;
      default: nxt_reg_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ea_vld_ff <= 1'h0;
      ea_ff <= `OAG_EA_RST;
      ram_hit_ff <= 1'h0;
      sfr_hit_ff <= 1'h0;
      reg_hit_ff <= 1'h0;
      reg_val_ff <= 16'h0000;
      fault_ff <= 1'h0;
    end else begin
      ea_vld_ff <= nxt_vld && is_mem;
      ea_ff <= nxt_ea;
      ram_hit_ff <= nxt_vld && is_mem && in_ram(nxt_ea);
      sfr_hit_ff <= nxt_vld && is_mem && in_sfr(nxt_ea);
      reg_hit_ff <= req_vld && is_reg;
      reg_val_ff <= nxt_reg_val;
      fault_ff <= nxt_fault;
    end
  end

  // checking helpers, read only by the properties below
  // taken from the raw image so a slip in the select module shows up
  logic [7:0] chk_byte;
  logic [15:0] chk_pair;
  logic [15:0] chk_base;
  logic [15:0] chk_ptr;
  logic saddr_req;
  logic sfr_req;
  logic stack_req;

  assign chk_byte = rf_image[{byte_code, 3'h0} +: 8];
  assign chk_pair = rf_image[{pair_code, 4'h0} +: 16];
  assign chk_base = rf_image[63:48];
  assign chk_ptr = rf_image[47:32];
  assign saddr_req = req_vld && (mode == oag_pkg::OAG_SADDR);
  assign sfr_req = req_vld && (mode == oag_pkg::OAG_SFR);
  assign stack_req = req_vld && (mode == oag_pkg::OAG_STACK);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // request checks look one edge after the request, where the pulses stand; flag range checks look at the same edge

  reset_clear_a: assert property (
    @(posedge clk_sys) disable iff (1'h0) srst |=>
      !ea_vld_ff && !ram_hit_ff && !sfr_hit_ff && !reg_hit_ff &&
      !fault_ff && ea_ff == `OAG_EA_RST)
    else $error("outputs not cleared by reset");

  saddr_window_a: assert property (
    saddr_req |=> !ea_vld_ff ||
      (ea_ff >= `OAG_SADDR_LO && ea_ff <= `OAG_SADDR_HI))
    else $error("short direct address left its window");

  saddr_region_a: assert property (
    saddr_req && !pair_op |=>
      ram_hit_ff == ($past(op_field) >= 8'h20) &&
      sfr_hit_ff == ($past(op_field) < 8'h20))
    else $error("short direct region select wrong");

  saddr_bit8_a: assert property (
    saddr_req ##0 (op_field < 8'h20) |=> ea_ff[8] && ea_vld_ff ||
      fault_ff)
    else $error("short direct bit 8 not set for low field");

  saddr_upper_a: assert property (
    saddr_req |=> ea_ff[15:9] == 7'h7F &&
      ea_ff[7:1] == $past(op_field[7:1]) &&
      ea_ff[8] == ($past(op_field) < 8'h20))
    else $error("short direct address layout wrong");

  saddr_vld_a: assert property (
    saddr_req && !pair_op |=> ea_vld_ff && !fault_ff && !reg_hit_ff)
    else $error("byte short direct request not accepted");

  saddr_field_a: assert property (
    saddr_req && !pair_op |=> ea_ff[7:0] == $past(op_field))
    else $error("short direct low byte not the field");

  pair_even_a: assert property (
    saddr_req && pair_op |=> !ea_ff[0] &&
      (fault_ff == $past(op_field[0])) &&
      (ea_vld_ff != fault_ff))
    else $error("pair short direct reached an odd address");

  sfr_page_a: assert property (
    sfr_req |=> ea_vld_ff && sfr_hit_ff && !ram_hit_ff)
    else $error("sfr access not flagged on sfr page");

  sfr_range_a: assert property (
    sfr_hit_ff |-> ea_vld_ff && ea_ff[15:8] == 8'hFF && !ram_hit_ff)
    else $error("sfr flag outside the sfr page");

  sfr_form_a: assert property (
    sfr_req |=> ea_ff == {8'hFF, $past(op_field)})
    else $error("sfr address not FFH over field");

  sfr_alias_a: assert property (
    sfr_req && op_field < 8'h20 |=>
      ea_ff == {7'h7F, 1'h1, $past(op_field)})
    else $error("sfr and short direct disagree");

  byte_sel_a: assert property (
    req_vld && mode == oag_pkg::OAG_REG8 |=>
      reg_hit_ff && !ea_vld_ff && reg_val_ff == {8'h00, $past(chk_byte)})
    else $error("byte register select wrong");

  reg_byte_only_a: assert property (
    req_vld && mode == oag_pkg::OAG_REG8 |=> !fault_ff && !ram_hit_ff &&
      !sfr_hit_ff)
    else $error("byte register request reached memory");

  pair_sel_a: assert property (
    req_vld && mode == oag_pkg::OAG_REG16 |=>
      reg_hit_ff && reg_val_ff == $past(chk_pair))
    else $error("register pair select wrong");

  pair_no_mem_a: assert property (
    req_vld && mode == oag_pkg::OAG_REG16 |=>
      !ea_vld_ff && !fault_ff && !ram_hit_ff && !sfr_hit_ff)
    else $error("register pair request reached memory");

  indirect_ea_a: assert property (
    req_vld && mode == oag_pkg::OAG_IND_PTR |=>
      ea_vld_ff && ea_ff == $past(chk_ptr))
    else $error("indirect through pointer pair wrong");

  indirect_base_a: assert property (
    req_vld && mode == oag_pkg::OAG_IND_BASE |=>
      ea_vld_ff && ea_ff == $past(chk_base))
    else $error("indirect through base pair wrong");

  indirect_any_a: assert property (
    req_vld && (mode == oag_pkg::OAG_IND_PTR ||
      mode == oag_pkg::OAG_IND_BASE) |=> !fault_ff && !reg_hit_ff)
    else $error("indirect request refused");

  based_sum_a: assert property (
    req_vld && mode == oag_pkg::OAG_BASED |=>
      ea_ff == 16'($past(chk_base) + {8'h00, $past(op_field)}))
    else $error("based address sum wrong");

  based_vld_a: assert property (
    req_vld && mode == oag_pkg::OAG_BASED |=> ea_vld_ff && !fault_ff)
    else $error("based request not accepted");

  stack_ptr_a: assert property (
    stack_req |=>
      ea_ff == 16'($past(stack_pointer) - {15'h0000, $past(push_op)}))
    else $error("stack address not from stack pointer");

  stack_ram_a: assert property (
    stack_req |=> (ea_vld_ff && ram_hit_ff) ^ fault_ff)
    else $error("stack access outside high-speed RAM");

  stack_range_a: assert property (
    stack_req |=> fault_ff == (ea_ff[15:8] != 8'hFE))
    else $error("stack fault does not match the RAM range");

  ram_range_a: assert property (
    ram_hit_ff |-> ea_vld_ff && ea_ff[15:8] == 8'hFE && !sfr_hit_ff)
    else $error("ram flag outside the high-speed RAM");

  fault_alone_a: assert property (
    fault_ff |-> !ea_vld_ff && !ram_hit_ff && !sfr_hit_ff && !reg_hit_ff)
    else $error("fault raised beside an accepted access");

  idle_quiet_a: assert property (
    !req_vld |=> !ea_vld_ff && !reg_hit_ff && !fault_ff)
    else $error("output without request");

  saddr_sfr_c: cover property (saddr_req && op_field < 8'h20 ##1
    sfr_hit_ff);
  based_wrap_c: cover property (req_vld && mode == oag_pkg::OAG_BASED &&
    chk_base == 16'hFFFF && op_field != 8'h00);
  stack_fault_c: cover property (stack_req ##1 fault_ff);
  push_ok_c: cover property (stack_req && push_op ##1 ea_vld_ff);
  reg_pair_c: cover property (req_vld && mode == oag_pkg::OAG_REG16 ##1
    reg_hit_ff);

endmodule

// >>> testbench/oag_rf_model.sv
// eight-byte register file on the core side of the generator
// assumes the bench loads one byte per cycle, driven at the falling edge
`timescale 1ns/1ns
module oag_rf_model (
  input wire logic clk_sys,
  input wire logic ld,
  input wire logic [2:0] ld_idx,
  input wire logic [7:0] ld_val,
  output logic [63:0] rf_image
);
  logic [7:0] bytes_ff [8];

  always_ff @(posedge clk_sys) begin
    if (ld) begin
      bytes_ff[ld_idx] <= ld_val;
    end
  end

  // byte n at bits 8n+7..8n, so pair n is {byte 2n+1, byte 2n}
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rf_image[8*i +: 8] = bytes_ff[i];
    end
  end
endmodule

// >>> testbench/operand_address_generator_tb_top.sv
// self-checking bench for the operand address generator
// assumes a one-cycle registered answer, sampled mid next cycle
`timescale 1ns/1ns
module operand_address_generator_tb_top;
  logic clk_sys, srst, req_vld, pair_op, push_op, ld;
  oag_pkg::oag_mode_t mode;
  logic [7:0] op_field, ld_val;
  logic [2:0] byte_code, ld_idx;
  logic [1:0] pair_code;
  logic [15:0] stack_pointer, ea, reg_val, keep;
  logic [63:0] rf_image;
  logic ea_vld, ram_hit, sfr_hit, reg_hit, fault;
  int num_errors, n_checks;

  oag_rf_model rf (.clk_sys(clk_sys), .ld(ld), .ld_idx(ld_idx),
    .ld_val(ld_val), .rf_image(rf_image));

  oag_top dut (.clk_sys(clk_sys), .srst(srst), .req_vld(req_vld),
    .mode(mode), .op_field(op_field), .byte_code(byte_code),
    .pair_code(pair_code), .pair_op(pair_op), .push_op(push_op),
    .rf_image(rf_image), .stack_pointer(stack_pointer),
    .ea_vld_ff(ea_vld), .ea_ff(ea), .ram_hit_ff(ram_hit),
    .sfr_hit_ff(sfr_hit), .reg_hit_ff(reg_hit), .reg_val_ff(reg_val),
    .fault_ff(fault));

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] bx(input int i);
    return 8'((i + 1) * 17);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic load(input logic [2:0] i, input logic [7:0] v);
    @(negedge clk_sys);
    ld = 1'h1;
    ld_idx = i;
    ld_val = v;
    @(negedge clk_sys);
    ld = 1'h0;
  endtask

  // returns mid-cycle after the taking edge, where the pulses stand
  task automatic go(input oag_pkg::oag_mode_t m, input logic [7:0] f);
    @(negedge clk_sys);
    mode = m;
    op_field = f;
    req_vld = 1'h1;
    @(negedge clk_sys);
    req_vld = 1'h0;
  endtask

  task automatic t_saddr;
    logic [7:0] fl [5] = '{8'h00, 8'h1F, 8'h20, 8'h90, 8'hFF};
    logic lo;
    foreach (fl[k]) begin
      lo = fl[k] < 8'h20;
      go(oag_pkg::OAG_SADDR, fl[k]);
      chk(ea, {7'h7F, lo, fl[k]});
      chk(16'({ram_hit, sfr_hit, ea_vld}), 16'({!lo, lo, 1'h1}));
    end
  endtask

  task automatic t_pair;
    pair_op = 1'h1;
    go(oag_pkg::OAG_SADDR, 8'h91);
    chk(16'({ea_vld, fault}), 16'h0001);
    go(oag_pkg::OAG_SADDR, 8'h90);
    chk(ea, 16'hFE90);
    chk(16'({ea_vld, fault}), 16'h0002);
    pair_op = 1'h0;
  endtask

  task automatic t_sfr;
    go(oag_pkg::OAG_SFR, 8'hFB);
    chk(ea, 16'hFFFB);
    chk(16'({sfr_hit, ea_vld}), 16'h0003);
    go(oag_pkg::OAG_SFR, 8'h1A);
    keep = ea;
    go(oag_pkg::OAG_SADDR, 8'h1A);
    chk(keep, 16'hFF1A);
    chk(ea, 16'hFF1A);
    chk(16'({sfr_hit, ea_vld}), 16'h0003);
  endtask

  task automatic t_reg;
    for (int i = 0; i < 8; i++) begin
      byte_code = 3'(i);
      go(oag_pkg::OAG_REG8, 8'h00);
      chk(reg_val, {8'h00, bx(i)});
      chk(16'({reg_hit, ea_vld}), 16'h0002);
    end
    for (int p = 0; p < 4; p++) begin
      pair_code = 2'(p);
      go(oag_pkg::OAG_REG16, 8'h00);
      chk(reg_val, {bx(2*p + 1), bx(2*p)});
    end
  endtask

  task automatic t_ind;
    go(oag_pkg::OAG_IND_PTR, 8'h00);
    chk(ea, 16'h6655);
    go(oag_pkg::OAG_IND_BASE, 8'h00);
    chk(ea, 16'h8877);
    go(oag_pkg::OAG_BASED, 8'hF0);
    chk(ea, 16'h8967);
    load(3'h6, 8'hFF);
    load(3'h7, 8'hFF);
    go(oag_pkg::OAG_BASED, 8'h02);
    chk(ea, 16'h0001);
    chk(16'(ea_vld), 16'h0001);
  endtask

  task automatic t_stack;
    stack_pointer = 16'hFE80;
    push_op = 1'h1;
    go(oag_pkg::OAG_STACK, 8'h00);
    chk(ea, 16'hFE7F);
    chk(16'({ram_hit, ea_vld, fault}), 16'h0006);
    push_op = 1'h0;
    go(oag_pkg::OAG_STACK, 8'h00);
    chk(ea, 16'hFE80);
    // push at the bottom edge of the RAM leaves it
    stack_pointer = 16'hFE00;
    push_op = 1'h1;
    go(oag_pkg::OAG_STACK, 8'h00);
    chk(16'({ea_vld, fault}), 16'h0001);
    push_op = 1'h0;
    stack_pointer = 16'hFF10;
    go(oag_pkg::OAG_STACK, 8'h00);
    chk(16'({ea_vld, fault}), 16'h0001);
  endtask

  initial begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end

  initial begin
    num_errors = 0;
    n_checks = 0;
    srst = 1'h1;
    {req_vld, pair_op, push_op, ld} = 4'h0;
    mode = oag_pkg::OAG_SADDR;
    {op_field, ld_val, byte_code, ld_idx, pair_code} = 24'h00_0000;
    stack_pointer = 16'h0000;
    repeat (3) @(negedge clk_sys);
    srst = 1'h0;
    chk(16'({ea_vld, ram_hit, sfr_hit, reg_hit, fault}), 16'h0000);
    chk(ea, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      load(3'(i), bx(i));
    end
    t_saddr();
    t_pair();
    t_sfr();
    t_reg();
    t_ind();
    t_stack();
    complete_run();
  end
endmodule
